//--- design/dpt_pkg.sv
// shared constants for the dual pwm timer: register map, fields, resets, timing
package dpt_pkg;
	// register offsets (8-bit data, 4-bit address)
	localparam logic [3:0] OFS_CONTROL     = 4'h0;
	localparam logic [3:0] OFS_DUTY_ONE_LO = 4'h1;
	localparam logic [3:0] OFS_DUTY_ONE_HI = 4'h2;
	localparam logic [3:0] OFS_PERIOD_ONE  = 4'h3;
	localparam logic [3:0] OFS_DUTY_TWO_LO = 4'h4;
	localparam logic [3:0] OFS_DUTY_TWO_HI = 4'h5;
	localparam logic [3:0] OFS_PERIOD_TWO  = 4'h6;
	localparam logic [3:0] OFS_FLAGS       = 4'h7;
	localparam logic [3:0] OFS_COUNT_ONE_LO = 4'h8;
	localparam logic [3:0] OFS_COUNT_ONE_HI = 4'h9;
	localparam logic [3:0] OFS_COUNT_TWO_LO = 4'hA;
	localparam logic [3:0] OFS_COUNT_TWO_HI = 4'hB;

	// control register field positions
	localparam int BIT_PRESCALE_ONE_SEL_LO = 0;
	localparam int BIT_PRESCALE_TWO_SEL_LO = 2;
	localparam int BIT_TIMER_ONE_ENABLE    = 4;
	localparam int BIT_TIMER_TWO_ENABLE    = 5;
	localparam int BIT_WAVEFORM_ONE_ENABLE = 6;
	localparam int BIT_WAVEFORM_TWO_ENABLE = 7;

	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIOD  = 8'h00;
	localparam logic [9:0] RST_DUTY    = 10'h000;

	// widths
	localparam int COUNT_W  = 10;
	localparam int PERIOD_W = 8;
	// width of the counter ticks per period step (the factor of four prescaler ticks)
	localparam int STEP_W   = 2;

	// prescaler select codes and ratios
	localparam logic [1:0] SEL_DIV2  = 2'h0;
	localparam logic [1:0] SEL_DIV8  = 2'h1;
	localparam logic [1:0] SEL_DIV32 = 2'h2;
	localparam logic [1:0] SEL_DIV64 = 2'h3;
	localparam logic [5:0] LAST_DIV2  = 6'h01;
	localparam logic [5:0] LAST_DIV8  = 6'h07;
	localparam logic [5:0] LAST_DIV32 = 6'h1F;
	localparam logic [5:0] LAST_DIV64 = 6'h3F;
endpackage

//--- design/dpt_chan_if.sv
// bundle between the register file and one pwm channel
`timescale 1ns/1ps
interface dpt_chan_if;
	import dpt_pkg::*;
	logic                timer_en;
	logic                tick;
	logic [PERIOD_W-1:0] period;
	logic [COUNT_W-1:0]  duty;
	logic                match;
	logic                wave;
	logic [COUNT_W-1:0]  count;

	modport ctrl (output timer_en, tick, period, duty, input match, wave, count);
	modport chan (input timer_en, tick, period, duty, output match, wave, count);
endinterface

//--- design/dpt_prescaler.sv
// selectable prescaler: one-cycle tick every 2, 8, 32 or 64 clocks
`timescale 1ns/1ps
module dpt_prescaler
	import dpt_pkg::*;
(
	// clock and reset
	input  logic       clk,
	input  logic       rst_n,
	// control
	input  logic       enable,
	input  logic [1:0] sel,
	// output
	output logic       tick
);
	logic [5:0] div_count;
	logic [5:0] last;

	// terminal count for the selected ratio
	always_comb begin
		case (sel)
			SEL_DIV2:  last = LAST_DIV2;
			SEL_DIV8:  last = LAST_DIV8;
			SEL_DIV32: last = LAST_DIV32;
			default:   last = LAST_DIV64;
		endcase
	end

	// held clear while stopped so a restart begins a full interval
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			div_count <= 6'h00;
			tick      <= 1'b0;
		end else if (div_count >= last) begin
			div_count <= 6'h00;
			tick      <= 1'b1;
		end else begin
			div_count <= div_count + 6'h01;
			tick      <= 1'b0;
		end
	end
endmodule

//--- design/dpt_channel.sv
// one pwm channel: up-counter, period match, duty shadow and waveform
`timescale 1ns/1ps
module dpt_channel
	import dpt_pkg::*;
(
	// clock and reset
	input  logic clk,
	input  logic rst_n,
	// register side
	dpt_chan_if.chan ch
);
	logic [COUNT_W-1:0] duty_shadow_latch;
	logic [COUNT_W-1:0] next_count;
	logic               at_period;

	// period spans four counts per period step, so duty keeps 10-bit resolution
	assign next_count = ch.count + 10'h001;
	assign at_period  = (ch.count == {ch.period, {STEP_W{1'b1}}});

	// counter, shadow latch and output; a stopped timer holds count, shadow and wave and clears match
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ch.count          <= 10'h000;
			duty_shadow_latch <= RST_DUTY;
			ch.wave           <= 1'b0;
			ch.match          <= 1'b0;
		end else if (ch.timer_en && ch.tick) begin
			if (at_period) begin
				ch.count          <= 10'h000;
				duty_shadow_latch <= ch.duty;
				ch.wave           <= (ch.duty != 10'h000);
				ch.match          <= 1'b1;
			end else begin
				ch.count <= next_count;
				ch.match <= 1'b0;
				if (next_count == duty_shadow_latch) begin
					ch.wave <= 1'b0;
				end
			end
		end else begin
			ch.match <= 1'b0;
		end
	end
endmodule

//--- design/dpt_timer.sv
// dual pwm timer top: register file, two prescalers, two channels, pin muxing
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dpt_timer
	import dpt_pkg::*;
(
	// clock and reset
	input  logic       clk,
	input  logic       rst_n,
	// register port
	input  logic [3:0] addr,
	input  logic [7:0] wdata,
	input  logic       wr,
	input  logic       rd,
	output logic [7:0] rdata,
	// ordinary port use of the two pins
	input  logic [1:0] port_data,
	input  logic [1:0] port_c_direction,
	// pins
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe,
	// status
	output logic [1:0] period_match_flag
);
	logic [7:0]          pwm_timer_control;
	logic [COUNT_W-1:0]  duty_one;
	logic [COUNT_W-1:0]  duty_two;
	logic [PERIOD_W-1:0] period_one;
	logic [PERIOD_W-1:0] period_two;
	logic [7:0]          next_rdata;
	logic [1:0]          wave_en;

	dpt_chan_if ch_one ();
	dpt_chan_if ch_two ();

	// control and setting registers; duty lands in the shadow only at rollover
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_timer_control <= RST_CONTROL;
			duty_one          <= RST_DUTY;
			duty_two          <= RST_DUTY;
			period_one        <= RST_PERIOD;
			period_two        <= RST_PERIOD;
		end else if (wr) begin
			if (addr == OFS_CONTROL) begin
				pwm_timer_control <= wdata;
			end else if (addr == OFS_DUTY_ONE_LO) begin
				duty_one[7:0] <= wdata;
			end else if (addr == OFS_DUTY_ONE_HI) begin
				duty_one[9:8] <= wdata[1:0];
			end else if (addr == OFS_PERIOD_ONE) begin
				period_one <= wdata;
			end else if (addr == OFS_DUTY_TWO_LO) begin
				duty_two[7:0] <= wdata;
			end else if (addr == OFS_DUTY_TWO_HI) begin
				duty_two[9:8] <= wdata[1:0];
			end else if (addr == OFS_PERIOD_TWO) begin
				period_two <= wdata;
			end
		end
	end

	// sticky flags: write one clears, a match in the same cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			period_match_flag <= 2'h0;
		end else begin
			period_match_flag <= (period_match_flag
				& ~((wr && addr == OFS_FLAGS) ? wdata[1:0] : 2'h0))
				| {ch_two.match, ch_one.match};
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (addr == OFS_CONTROL) begin
			next_rdata = pwm_timer_control;
		end else if (addr == OFS_DUTY_ONE_LO) begin
			next_rdata = duty_one[7:0];
		end else if (addr == OFS_DUTY_ONE_HI) begin
			next_rdata = {6'h00, duty_one[9:8]};
		end else if (addr == OFS_PERIOD_ONE) begin
			next_rdata = period_one;
		end else if (addr == OFS_DUTY_TWO_LO) begin
			next_rdata = duty_two[7:0];
		end else if (addr == OFS_DUTY_TWO_HI) begin
			next_rdata = {6'h00, duty_two[9:8]};
		end else if (addr == OFS_PERIOD_TWO) begin
			next_rdata = period_two;
		end else if (addr == OFS_FLAGS) begin
			next_rdata = {6'h00, period_match_flag};
		end else if (addr == OFS_COUNT_ONE_LO) begin
			next_rdata = ch_one.count[7:0];
		end else if (addr == OFS_COUNT_ONE_HI) begin
			next_rdata = {6'h00, ch_one.count[9:8]};
		end else if (addr == OFS_COUNT_TWO_LO) begin
			next_rdata = ch_two.count[7:0];
		end else if (addr == OFS_COUNT_TWO_HI) begin
			next_rdata = {6'h00, ch_two.count[9:8]};
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

	// each channel sees only its own settings
	assign ch_one.timer_en = pwm_timer_control[BIT_TIMER_ONE_ENABLE];
	assign ch_one.period   = period_one;
	assign ch_one.duty     = duty_one;
	assign ch_two.timer_en = pwm_timer_control[BIT_TIMER_TWO_ENABLE];
	assign ch_two.period   = period_two;
	assign ch_two.duty     = duty_two;

	dpt_prescaler u_pre_one (
		.clk    (clk),
		.rst_n  (rst_n),
		.enable (ch_one.timer_en),
		.sel    (pwm_timer_control[BIT_PRESCALE_ONE_SEL_LO +: 2]),
		.tick   (ch_one.tick)
	);

	dpt_prescaler u_pre_two (
		.clk    (clk),
		.rst_n  (rst_n),
		.enable (ch_two.timer_en),
		.sel    (pwm_timer_control[BIT_PRESCALE_TWO_SEL_LO +: 2]),
		.tick   (ch_two.tick)
	);

	dpt_channel u_chan_one (
		.clk   (clk),
		.rst_n (rst_n),
		.ch    (ch_one.chan)
	);

	dpt_channel u_chan_two (
		.clk   (clk),
		.rst_n (rst_n),
		.ch    (ch_two.chan)
	);

	assign wave_en = {pwm_timer_control[BIT_WAVEFORM_TWO_ENABLE],
		pwm_timer_control[BIT_WAVEFORM_ONE_ENABLE]};

	// pin mux registered so the pins come from flops; costs one cycle of lag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_out <= 2'h0;
			pin_oe  <= 2'h0;
		end else begin
			pin_out <= (wave_en & {ch_two.wave, ch_one.wave})
				| (~wave_en & port_data);
			pin_oe  <= wave_en | port_c_direction;
		end
	end
endmodule

//--- test/dpt_timer_checker.sv
// concurrent checks on the dual pwm timer top ports
`timescale 1ns/1ps
module dpt_timer_checker
	import dpt_pkg::*;
(
	// clock and reset
	input logic       clk,
	input logic       rst_n,
	// register port
	input logic [3:0] addr,
	input logic [7:0] wdata,
	input logic       wr,
	input logic       rd,
	input logic [7:0] rdata,
	// pins and status
	input logic [1:0] port_data,
	input logic [1:0] port_c_direction,
	input logic [1:0] pin_out,
	input logic [1:0] pin_oe,
	input logic [1:0] period_match_flag
);
	logic [7:0] ctl;
	logic       clr1;

	// software clear of the channel one flag
	assign clr1 = wr && addr == OFS_FLAGS && wdata[0];

	// control copy tracked from bus writes, so pin checks need no internals
	always_ff @(posedge clk) begin
		if (!rst_n)
			ctl <= RST_CONTROL;
		else if (wr && addr == OFS_CONTROL)
			ctl <= wdata;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_reads_zero: assert property ($past(rd) && $past(addr) > 4'hB |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_control_read_back: assert property ($past(rd) && $past(addr) == OFS_CONTROL
		|-> rdata == $past(ctl))
		else $error("control read back wrong");
	a_flag_stays_set: assert property ($past(period_match_flag[0]) && !$past(clr1)
		|-> period_match_flag[0])
		else $error("flag dropped without clear");
	a_wave_one_drives: assert property ($past(ctl[6]) |-> pin_oe[0])
		else $error("pin one not driven with wave on");
	a_wave_two_drives: assert property ($past(ctl[7]) |-> pin_oe[1])
		else $error("pin two not driven with wave on");
	// pins come out of reset low, so the cycle right after release is not a pass-through
	a_port_passes_through: assert property ($past(rst_n) && !$past(ctl[6])
		|-> pin_oe[0] == $past(port_c_direction[0]) && pin_out[0] == $past(port_data[0]))
		else $error("port use of pin one wrong");
	a_rise_sets_flag: assert property ($past(ctl[6]) && $past(ctl[6], 2)
		&& $rose(pin_out[0]) |-> period_match_flag[0])
		else $error("period start without flag");
	a_stopped_pin_holds: assert property ($past(ctl[6]) && $past(ctl[6], 2)
		&& !$past(ctl[4]) && !$past(ctl[4], 2) |-> $stable(pin_out[0]))
		else $error("pin moved with timer off");
endmodule

bind dpt_timer dpt_timer_checker chk_i (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
	.port_data, .port_c_direction, .pin_out, .pin_oe, .period_match_flag);

//--- test/dpt_load.sv
// pwm load model: measures high time and period of a driven pin
`timescale 1ns/1ps
module dpt_load (
	// clock
	input  logic        clk,
	// pin
	input  logic        pin_out,
	input  logic        pin_oe,
	// measurements in clocks
	output logic [15:0] high_len,
	output logic [15:0] per_len
);
	logic        lvl_q   = 1'b0;
	logic [15:0] hi_cnt  = 16'h0000;
	logic [15:0] per_cnt = 16'h0000;
	logic        lvl;

	// a pin not driven reads low here, so port use with its direction bit clear never counts as pulses
	assign lvl = pin_oe & pin_out;

	// rising edges start both counts, falling edge ends the high count
	always_ff @(posedge clk) begin
		lvl_q <= lvl;
		per_cnt <= per_cnt + 16'h0001;
		if (lvl)
			hi_cnt <= hi_cnt + 16'h0001;
		if (lvl && !lvl_q) begin
			per_len <= per_cnt;
			per_cnt <= 16'h0001;
			hi_cnt <= 16'h0001;
		end
		if (!lvl && lvl_q)
			high_len <= hi_cnt;
	end
endmodule

//--- test/test_dpt_timer.sv
// self-checking bench for the dual pwm timer
`timescale 1ns/1ps
module test_dpt_timer import dpt_pkg::*;;
	logic        clk;
	logic        rst_n;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [1:0]  port_data;
	logic [1:0]  port_c_direction;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  period_match_flag;
	logic [15:0] hi1, per1, hi2, per2;
	int          errors;
	int          cmp_count;
	int          ratio [4] = '{2, 8, 32, 64};

	dpt_timer uut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .port_data,
		.port_c_direction, .pin_out, .pin_oe, .period_match_flag);
	dpt_load load1 (.clk, .pin_out(pin_out[0]), .pin_oe(pin_oe[0]), .high_len(hi1), .per_len(per1));
	dpt_load load2 (.clk, .pin_out(pin_out[1]), .pin_oe(pin_oe[1]), .high_len(hi2), .per_len(per2));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic summarize();
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard well beyond the planned run
	initial begin
		#5000000;
		errors++;
		summarize();
	end

	initial begin
		logic [7:0] d;
		int         n;
		errors = 0;
		cmp_count = 0;
		{rst_n, addr, wdata, wr, rd, port_data, port_c_direction} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset state of control, duties, periods and flags
		for (int a = 0; a < 8; a++) begin
			rd_reg(a[3:0], d);
			chk(d, 8'h00);
		end
		wr_reg(OFS_PERIOD_ONE, 8'h01);
		rd_reg(OFS_PERIOD_ONE, d);
		chk(d, 8'h01);
		wr_reg(4'hC, 8'hFF);
		rd_reg(4'hC, d);
		chk(d, 8'h00);
		wr_reg(OFS_DUTY_ONE_LO, 8'h03);
		wr_reg(OFS_DUTY_TWO_LO, 8'h01);
		// wave off: the pins carry ordinary port use
		port_data <= 2'b10;
		port_c_direction <= 2'b11;
		repeat (3) @(posedge clk);
		chk(pin_oe, 2'b11);
		chk(pin_out, 2'b10);
		// every select code, the two channels on opposite codes
		for (int s = 0; s < 4; s++) begin
			wr_reg(OFS_CONTROL, {4'hF, 2'(3 - s), 2'(s)});
			repeat (2000) @(posedge clk);
			chk(per1, 16'(8 * ratio[s]));
			chk(hi1, 16'(3 * ratio[s]));
			chk(per2, 16'(4 * ratio[3 - s]));
			chk(hi2, 16'(ratio[3 - s]));
		end
		rd_reg(OFS_FLAGS, d);
		chk(d, 8'h03);
		// timers off: no period match may set a cleared flag
		wr_reg(OFS_CONTROL, 8'hC0);
		wr_reg(OFS_FLAGS, 8'h03);
		repeat (600) @(posedge clk);
		rd_reg(OFS_FLAGS, d);
		chk(d, 8'h00);
		// zero duty, taken at the next rollover, keeps the pin low
		wr_reg(OFS_DUTY_ONE_LO, 8'h00);
		wr_reg(OFS_CONTROL, 8'h50);
		repeat (100) @(posedge clk);
		n = 0;
		repeat (50) begin
			@(posedge clk);
			if (pin_out[0] !== 1'b0)
				n++;
		end
		chk(16'(n), 16'h0000);
		rd_reg(OFS_FLAGS, d);
		chk(d, 8'h01);
		// second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		chk(period_match_flag, 2'b00);
		rd_reg(OFS_CONTROL, d);
		chk(d, 8'h00);
		// counters restart from zero after any reset
		for (int a = 8; a < 12; a++) begin
			rd_reg(a[3:0], d);
			chk(d, 8'h00);
		end
		// upper duty half keeps only its two bits
		wr_reg(OFS_DUTY_TWO_HI, 8'hFF);
		rd_reg(OFS_DUTY_TWO_HI, d);
		chk(d, 8'h03);
		// plain timer on channel two: wave left off, pin stays with the port
		wr_reg(OFS_PERIOD_TWO, 8'h02);
		rd_reg(OFS_PERIOD_TWO, d);
		chk(d, 8'h02);
		wr_reg(OFS_CONTROL, 8'h20);
		repeat (100) @(posedge clk);
		rd_reg(OFS_FLAGS, d);
		chk(d, 8'h02);
		chk(pin_oe, 2'b11);
		chk(pin_out, 2'b10);
		summarize();
	end
endmodule
